/* File: rtl/opfsc_pkg.sv */
// Package for the output-pin, FIFO threshold and sync word register bank.
// Assumes an upstream serial interface decoder that turns host frames
// into single-cycle register reads and writes.
package opfsc_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 7;

  // Register offsets
  localparam logic [5:0] OFS_PIN2_CFG  = 6'h00;
  localparam logic [5:0] OFS_PIN1_CFG  = 6'h01;
  localparam logic [5:0] OFS_PIN0_CFG  = 6'h02;
  localparam logic [5:0] OFS_FILL_THRESHOLD_FIELD  = 6'h03;
  localparam logic [5:0] OFS_SYNC_HIGH = 6'h04;
  localparam logic [5:0] OFS_SYNC_LOW  = 6'h05;

  // Field positions
  localparam int unsigned BIT_INVERT   = 6;
  localparam int unsigned BIT_DRIVE    = 7;
  localparam int unsigned BIT_TEMP_EN  = 7;
  localparam int unsigned BIT_RSVD_P2  = 7;
  localparam int unsigned SEL_MSB      = 5;
  localparam int unsigned THR_MSB      = 3;

  // Reset values
  localparam logic [7:0] RST_PIN2_CFG  = 8'h29;
  localparam logic [7:0] RST_PIN1_CFG  = 8'h2E;
  localparam logic [7:0] RST_PIN0_CFG  = 8'h3F;
  localparam logic [7:0] RST_FILL_THRESHOLD_FIELD  = 8'h07;
  localparam logic [7:0] RST_SYNC_HIGH = 8'hD3;
  localparam logic [7:0] RST_SYNC_LOW  = 8'h91;

  // Threshold arithmetic
  localparam logic [6:0] TX_THR_BASE   = 7'h3D;
  localparam logic [6:0] RX_THR_STEP1  = 7'h01;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [5:0]       addr;
    logic [7:0]       wdata;
  } opfsc_req_t;

  typedef struct packed {
    logic             drive_strength;
    logic             temp_sensor_en;
    logic [5:0]       pin2_signal_select;
    logic [5:0]       pin1_signal_select;
    logic [5:0]       pin0_signal_select;
  } opfsc_pin_cfg_t;

endpackage

/* File: rtl/opfsc_regs.sv */
// Output-pin, FIFO threshold and sync word configuration registers.
// Assumes register requests are single-cycle strobes from the serial
// interface decoder, and that the signal-select table lives outside.
//
// Overview of operation
// - Register contents stay unchanged while the device sleeps.
// - Bit 6 of each pin register inverts that pin's selected signal.
// - Pin 2 select field resets to 0x29, the chip-ready indication.
// - Pin 1 register bit 7 sets drive strength for all pins; resets 0.
// - Pin 1 select field resets to 0x2E, high impedance.
// - Pin 0 bit 7 enables temperature sensor; other bits then zero; the bank stores them as written and does not clear them.
// - Pin 0 select field resets to 0x3F, crystal clock divided by 192.
// - Threshold exceeded when FIFO byte count is at least threshold.
// - Field N gives RX 4*(N+1), TX 61-4*N bytes; resets to 7.
// - Sync high register holds sync word bits 15:8, reset 0xD3.
// - Sync low register holds sync word bits 7:0, reset 0x91.
module opfsc_regs (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  sleep_state,
  input  wire opfsc_pkg::opfsc_req_t req,
  output logic [7:0]                 rdata,
  output logic                       rdata_valid,
  input  wire logic [2:0]            pin_selected,
  output logic [2:0]                 pin_out,
  output opfsc_pkg::opfsc_pin_cfg_t  pin_cfg,
  input  wire logic [6:0]            tx_fifo_bytes,
  input  wire logic [6:0]            rx_fifo_bytes,
  output logic                       tx_thr_exceeded,
  output logic                       rx_thr_exceeded,
  output logic [15:0]                sync_word
);
  import opfsc_pkg::*;

  logic [7:0] pin2_cfg;
  logic [7:0] pin1_cfg;
  logic [7:0] pin0_cfg;
  logic [7:0] fifo_threshold;
  logic [7:0] sync_word_high;
  logic [7:0] sync_word_low;

  // Writes are dropped while asleep so nothing disturbs retained state
  wire        wr_ok     = req.wr && !sleep_state;
  wire        wr_pin2   = wr_ok && (req.addr == OFS_PIN2_CFG);
  wire        wr_pin1   = wr_ok && (req.addr == OFS_PIN1_CFG);
  wire        wr_pin0   = wr_ok && (req.addr == OFS_PIN0_CFG);
  wire        wr_thr    = wr_ok && (req.addr == OFS_FILL_THRESHOLD_FIELD);
  wire        wr_shigh  = wr_ok && (req.addr == OFS_SYNC_HIGH);
  wire        wr_slow   = wr_ok && (req.addr == OFS_SYNC_LOW);

  wire [7:0]  pin2_view = {1'b0, pin2_cfg[6:0]};
  wire [3:0]  thr_n     = fifo_threshold[THR_MSB:0];
  wire [6:0]  rx_thr    = 7'(({3'h0, thr_n} + RX_THR_STEP1) << 2);
  wire [6:0]  tx_thr    = TX_THR_BASE - {1'b0, thr_n, 2'b00};
  wire [2:0]  pin_inv   = {pin2_cfg[BIT_INVERT], pin1_cfg[BIT_INVERT],
                           pin0_cfg[BIT_INVERT]};

  logic [7:0] next_rdata;
  always_comb begin
    case (req.addr)
      OFS_PIN2_CFG:  next_rdata = pin2_view;
      OFS_PIN1_CFG:  next_rdata = pin1_cfg;
      OFS_PIN0_CFG:  next_rdata = pin0_cfg;
      OFS_FILL_THRESHOLD_FIELD:  next_rdata = fifo_threshold;
      OFS_SYNC_HIGH: next_rdata = sync_word_high;
      OFS_SYNC_LOW:  next_rdata = sync_word_low;
      default:       next_rdata = 8'h00;
    endcase
  end

  // Only a power-on reset clears these; sleep never does
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin2_cfg       <= RST_PIN2_CFG;
      pin1_cfg       <= RST_PIN1_CFG;
      pin0_cfg       <= RST_PIN0_CFG;
      fifo_threshold <= RST_FILL_THRESHOLD_FIELD;
      sync_word_high <= RST_SYNC_HIGH;
      sync_word_low  <= RST_SYNC_LOW;
    end else begin
      if (wr_pin2) begin
        pin2_cfg <= {1'b0, req.wdata[6:0]};
      end
      if (wr_pin1) begin
        pin1_cfg <= req.wdata;
      end
      // Temp sensor mode trusts the host to clear the other bits
      if (wr_pin0) begin
        pin0_cfg <= req.wdata;
      end
      // Reserved bits stored as written; host keeps them zero
      if (wr_thr) begin
        fifo_threshold <= req.wdata;
      end
      if (wr_shigh) begin
        sync_word_high <= req.wdata;
      end
      if (wr_slow) begin
        sync_word_low <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata       <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= req.rd;
      if (req.rd) begin
        rdata <= next_rdata;
      end
    end
  end

  // Registered pin and threshold outputs keep glitches off the pads
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_out         <= 3'h0;
      tx_thr_exceeded <= 1'b0;
      rx_thr_exceeded <= 1'b0;
    end else begin
      pin_out         <= pin_selected ^ pin_inv;
      tx_thr_exceeded <= (tx_fifo_bytes >= tx_thr);
      rx_thr_exceeded <= (rx_fifo_bytes >= rx_thr);
    end
  end

  assign pin_cfg.drive_strength     = pin1_cfg[BIT_DRIVE];
  assign pin_cfg.temp_sensor_en     = pin0_cfg[BIT_TEMP_EN];
  assign pin_cfg.pin2_signal_select = pin2_cfg[SEL_MSB:0];
  assign pin_cfg.pin1_signal_select = pin1_cfg[SEL_MSB:0];
  assign pin_cfg.pin0_signal_select = pin0_cfg[SEL_MSB:0];
  assign sync_word                  = {sync_word_high, sync_word_low};

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_SLEEP_HOLDS: assert property (
    sleep_state |=> $stable(sync_word) && $stable(pin_cfg) && $stable(fifo_threshold))
    else $error("Register changed while asleep");

  AST_PIN_INVERT: assert property (
    1'b1 |=> pin_out == ($past(pin_selected) ^ $past(pin_inv)))
    else $error("Pin output does not follow select and invert");

  AST_RESET_VALUES: assert property (
    $rose(rst_n) |-> pin_cfg.pin2_signal_select == 6'h29
      && pin_cfg.pin1_signal_select == 6'h2E && pin_cfg.pin0_signal_select == 6'h3F
      && !pin_cfg.drive_strength && sync_word == 16'hD391 && thr_n == 4'h7)
    else $error("Reset values wrong");

  AST_DRIVE_WRITE: assert property (
    wr_pin1 |=> pin_cfg.drive_strength == $past(req.wdata[7]))
    else $error("Drive strength not written");

  AST_TEMP_WRITE: assert property (
    wr_pin0 |=> pin_cfg.temp_sensor_en == $past(req.wdata[7]))
    else $error("Temperature enable not written");

  AST_RX_THRESHOLD: assert property (
    1'b1 |=> rx_thr_exceeded == ($past(rx_fifo_bytes) >= 7'(4 * ($past(thr_n) + 1))))
    else $error("RX threshold compare wrong");

  AST_TX_THRESHOLD: assert property (
    1'b1 |=> tx_thr_exceeded == ($past(tx_fifo_bytes) >= 7'(61 - 4 * $past(thr_n))))
    else $error("TX threshold compare wrong");

  AST_SYNC_HIGH_WRITE: assert property (
    wr_shigh |=> sync_word[15:8] == $past(req.wdata))
    else $error("Sync high byte not written");

  AST_SYNC_LOW_WRITE: assert property (
    wr_slow |=> sync_word[7:0] == $past(req.wdata))
    else $error("Sync low byte not written");

  AST_PIN2_RSVD_READ: assert property (
    req.rd && req.addr == OFS_PIN2_CFG |=> rdata_valid && !rdata[7])
    else $error("Reserved bit read as one");

  // Separate reset checks so a failure names the register at fault
  AST_PIN2_RESET: assert property (
    $rose(rst_n) |-> pin2_cfg == 8'h29)
    else $error("Pin 2 reset value wrong");

  AST_PIN1_RESET: assert property (
    $rose(rst_n) |-> pin_cfg.pin1_signal_select == 6'h2E && !pin1_cfg[BIT_INVERT])
    else $error("Pin 1 reset value wrong");

  AST_PIN0_RESET: assert property (
    $rose(rst_n) |-> pin_cfg.pin0_signal_select == 6'h3F && !pin_cfg.temp_sensor_en)
    else $error("Pin 0 reset value wrong");

  AST_THR_RESET_LEVELS: assert property (
    $rose(rst_n) |-> rx_thr == 7'h20 && tx_thr == 7'h21)
    else $error("Threshold levels after reset wrong");

  AST_THR_WRITE: assert property (
    wr_thr |=> thr_n == $past(req.wdata[THR_MSB:0]))
    else $error("Threshold field not written");

  AST_INVERT_WRITE: assert property (
    wr_pin1 |=> pin_inv[1] == $past(req.wdata[BIT_INVERT]))
    else $error("Pin 1 invert bit not written");

  // Bit 7 of pin 2 is never stored, whatever the host sends
  AST_PIN2_RSVD_STORE: assert property (
    wr_pin2 |=> !pin2_cfg[BIT_RSVD_P2])
    else $error("Reserved pin 2 bit stored");

  AST_SLEEP_WRITE_DROPPED: assert property (
    sleep_state && req.wr |=> $stable(pin2_cfg) && $stable(pin1_cfg) && $stable(pin0_cfg))
    else $error("Write landed while asleep");

  // Sync bytes only move on their own write strobe
  AST_SYNC_HIGH_HOLD: assert property (
    !wr_shigh |=> $stable(sync_word[15:8]))
    else $error("Sync high byte changed without a write");

  AST_SYNC_LOW_HOLD: assert property (
    !wr_slow |=> $stable(sync_word[7:0]))
    else $error("Sync low byte changed without a write");

  COV_SLEEP_WRITE: cover property (sleep_state && req.wr);
  COV_TX_HIT:      cover property ($rose(tx_thr_exceeded));
  COV_RX_HIT:      cover property ($rose(rx_thr_exceeded));
  COV_TEMP_ON:     cover property ($rose(pin_cfg.temp_sensor_en));

endmodule

/* File: test/opfsc_host.sv */
// Host model issuing single-cycle register strobes to the bank.
// Assumes every task is entered in the time step of a rising edge.
module opfsc_host (
  input  wire logic             clk_sys,
  input  wire logic [7:0]       rdata,
  input  wire logic             rdata_valid,
  output opfsc_pkg::opfsc_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  import opfsc_pkg::*;
  initial req = '0;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    if (a == OFS_FILL_THRESHOLD_FIELD) d[7:4] = 4'h0;
    if (a == OFS_PIN0_CFG && d[7]) d = 8'h80;
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] q, output logic v);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    q = rdata;
    v = rdata_valid;
    @(posedge clk_sys);
  endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the configuration register bank.
// Assumes all register traffic goes through the host model.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import opfsc_pkg::*;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
  logic           clk_sys = 0;
  logic           rst_n = 0;
  logic           sleep_state = 0;
  logic [2:0]     pin_selected = '0;
  logic [6:0]     tx_fifo_bytes = '0;
  logic [6:0]     rx_fifo_bytes = '0;
  logic [7:0]     rdata, q;
  logic           rdata_valid, v, tx_thr_exceeded, rx_thr_exceeded;
  logic [2:0]     pin_out;
  logic [15:0]    sync_word;
  opfsc_req_t     req;
  opfsc_pin_cfg_t pin_cfg;
  logic [7:0]     shadow [6];
  int             error_cnt = 0, checked = 0, seed = 21, cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  opfsc_host opfsc_host_i (.clk_sys(clk_sys), .rdata(rdata), .rdata_valid(rdata_valid),
    .req(req));
  opfsc_regs opfsc_regs_i (.clk_sys(clk_sys), .rst_n(rst_n), .sleep_state(sleep_state),
    .req(req), .rdata(rdata), .rdata_valid(rdata_valid), .pin_selected(pin_selected),
    .pin_out(pin_out), .pin_cfg(pin_cfg), .tx_fifo_bytes(tx_fifo_bytes),
    .rx_fifo_bytes(rx_fifo_bytes), .tx_thr_exceeded(tx_thr_exceeded),
    .rx_thr_exceeded(rx_thr_exceeded), .sync_word(sync_word));
  function automatic logic [7:0] exp_reg(input int a, input logic [7:0] d);
    if (a == 0) return d & 8'h7F;
    if (a == 3) return d & 8'h0F;
    if (a == 2 && d[7]) return 8'h80;
    return d;
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check_all();
    for (int a = 0; a < 6; a++) begin
      opfsc_host_i.rd(6'(a), q, v);
      `CHK(v, 1'b1)
      `CHK(q, shadow[a])
    end
    `CHK(sync_word, {shadow[4], shadow[5]})
    `CHK(pin_cfg.drive_strength, shadow[1][7])
    `CHK(pin_cfg.temp_sensor_en, shadow[2][7])
    `CHK(pin_cfg.pin2_signal_select, shadow[0][5:0])
    `CHK(pin_cfg.pin1_signal_select, shadow[1][5:0])
    `CHK(pin_cfg.pin0_signal_select, shadow[2][5:0])
  endtask
  // Counts one below and at the threshold; fill-level boundary only
  task automatic thr(input int n);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      tx_fifo_bytes <= 7'(61 - 4 * n - 1 + k);
      rx_fifo_bytes <= 7'(4 * (n + 1) - 1 + k);
      @(posedge clk_sys);
      #1;
      `CHK(tx_thr_exceeded, k[0])
      `CHK(rx_thr_exceeded, k[0])
    end
    @(posedge clk_sys);
  endtask
  task automatic pins();
    logic [2:0] s;
    s = 3'($random(seed));
    pin_selected <= s;
    @(posedge clk_sys);
    #1;
    `CHK(pin_out, s ^ {shadow[0][6], shadow[1][6], shadow[2][6]})
    @(posedge clk_sys);
  endtask
  initial begin
    // Shadow starts at reset values so early invert checks see known bits
    shadow = '{RST_PIN2_CFG, RST_PIN1_CFG, RST_PIN0_CFG, RST_FILL_THRESHOLD_FIELD,
               RST_SYNC_HIGH, RST_SYNC_LOW};
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK(pin_cfg.pin2_signal_select, 6'h29)
    `CHK(pin_cfg.pin1_signal_select, 6'h2E)
    `CHK(pin_cfg.pin0_signal_select, 6'h3F)
    `CHK(pin_cfg.drive_strength, 1'b0)
    `CHK(sync_word, 16'hD391)
    thr(7);
    $display("test reset done");
    // All-ones first round hits the reserved and sensor bits
    for (int i = 0; i < 18; i++) begin
      q = (i < 6) ? 8'hFF : 8'($random(seed));
      opfsc_host_i.wr(6'(i % 6), q);
      shadow[i % 6] = exp_reg(i % 6, q);
      if (i % 6 == 5) check_all();
      pins();
    end
    opfsc_host_i.rd(6'h3F, q, v);
    `CHK(q, 8'h00)
    $display("test access done");
    sleep_state <= 1'b1;
    for (int a = 0; a < 6; a++) opfsc_host_i.wr(6'(a), ~shadow[a]);
    sleep_state <= 1'b0;
    check_all();
    $display("test sleep done");
    for (int n = 0; n < 16; n++) begin
      opfsc_host_i.wr(OFS_FILL_THRESHOLD_FIELD, 8'(n));
      thr(n);
    end
    $display("test threshold done");
    opfsc_host_i.wr(OFS_PIN2_CFG, 8'h2E);
    opfsc_host_i.wr(OFS_PIN0_CFG, 8'h2E);
    `CHK(pin_cfg.pin2_signal_select, 6'h2E)
    `CHK(pin_cfg.pin0_signal_select, 6'h2E)
    $display("test power-down done");
    // Second reset mid-run must undo the power-down settings
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK(pin_cfg.pin2_signal_select, 6'h29)
    `CHK(pin_cfg.pin0_signal_select, 6'h3F)
    `CHK(pin_cfg.temp_sensor_en, 1'b0)
    `CHK(sync_word, 16'hD391)
    $display("test mid-run reset done");
    @(posedge clk_sys);
    wrap_up();
  end
endmodule
